// File: bench/lock_regs_sva.sv
// port assertions for the lock register bank
`timescale 1ns/1ns
`default_nettype none
module lock_regs_sva
(
    input wire logic                      clk_in,
    input wire logic                      rst_n_in,
    input wire logic                      sen_in,
    input wire logic                      vco_edge_in,
    input wire logic                      general_output_port_in,
    input wire logic                      sdo_out,
    input wire logic                      sdo_oe_out,
    input wire lock_regs_pkg::analog_en_t analog_out,
    input wire logic                      locked_out,
    input wire logic                      relock_req_out
);
    logic [7:0] vn_q;
    logic [7:0] vn_d;
    logic [7:0] idl_q;
    logic [7:0] idl_d;
    logic       v_q;
    // vco rises seen and cycles since the last frame
    always_comb
    begin
        vn_d  = vn_q + 8'(vco_edge_in && !v_q && vn_q != 8'hFF);
        idl_d = sen_in ? 8'h00 : idl_q + 8'(idl_q != 8'hFF);
    end
    always_ff @(posedge clk_in)
    begin
        v_q   <= vco_edge_in;
        vn_q  <= rst_n_in ? vn_d : 8'h00;
        idl_q <= rst_n_in ? idl_d : 8'h00;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_idle8; !sen_in [*8]; endsequence
    sequence s_pulse; relock_req_out ##1 !relock_req_out; endsequence
    property p_relock_pulse; relock_req_out |-> s_pulse; endproperty
    property p_relock_unlocked; relock_req_out |=> !locked_out; endproperty
    property p_reset_analog; $rose(rst_n_in) |=> analog_out == 8'hFC; endproperty
    property p_reset_oe; $rose(rst_n_in) |-> !sdo_oe_out && !locked_out; endproperty
    property p_oe_idle; s_idle8 |=> $stable(sdo_oe_out); endproperty
    property p_gpo;
        s_idle8 ##0 (sdo_oe_out && $stable(general_output_port_in)) [*4] |-> sdo_out == general_output_port_in;
    endproperty
    property p_lock_counts; $rose(locked_out) |-> vn_q >= 8'd5; endproperty
    property p_oe_rise; $rose(sdo_oe_out) |-> idl_q < 8'd12; endproperty
    property p_analog_idle; s_idle8 |=> $stable(analog_out); endproperty
    a_relock_pulse: assert property (p_relock_pulse) else $error("relock pulse too long");
    a_relock_unlocked: assert property (p_relock_unlocked) else $error("locked after relock");
    a_reset_analog: assert property (p_reset_analog) else $error("analog reset value");
    a_reset_oe: assert property (p_reset_oe) else $error("outputs after reset");
    a_oe_idle: assert property (p_oe_idle) else $error("pad enable moved idle");
    a_gpo: assert property (p_gpo) else $error("output port not driven");
    a_lock_counts: assert property (p_lock_counts) else $error("lock too early");
    a_oe_rise: assert property (p_oe_rise) else $error("pad enable rose idle");
    a_analog_idle: assert property (p_analog_idle) else $error("enables moved idle");
endmodule
`default_nettype wire

// File: bench/serial_host.sv
// serial host model that frames register reads and writes
`timescale 1ns/1ns
`default_nettype none
module serial_host
(
    input wire logic clk_in,
    input wire logic sdo_in,
    input wire logic oe_in,
    output logic     sck_out,
    output logic     sen_out,
    output logic     sdi_out
);
    logic oe_end;
    initial
    begin
        sck_out = 1'b0;
        sen_out = 1'b0;
        sdi_out = 1'b0;
        oe_end  = 1'b0;
    end
    // clock stands low between frames, each level held hold cycles
    task automatic xfer(input logic rw, input logic [2:0] c, input logic [4:0] a, input logic [23:0] d,
                        input int hold, output logic [23:0] r);
        logic [32:0] b;
        b = {rw, c, a, d};
        r = 24'h000000;
        sen_out = 1'b1;
        for (int i = 32; i >= 0; i--)
        begin
            sdi_out = b[i];
            repeat (hold) @(negedge clk_in);
            sck_out = 1'b1;
            repeat (hold) @(negedge clk_in);
            if (i < 24)
                r = {r[22:0], sdo_in};
            sck_out = 1'b0;
        end
        repeat (hold) @(negedge clk_in);
        oe_end = oe_in;
        sen_out = 1'b0;
        sdi_out = ~sdi_out;
        repeat (hold) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the lock register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_in = 1'b0, rst_n_in = 1'b0, ref_edge_in = 1'b0, vco_edge_in = 1'b0, general_output_port_in = 1'b0;
    logic sck_in, sen_in, sdi_in, sdo_out, sdo_oe_out, locked_out, relock_req_out;
    lock_regs_pkg::analog_en_t analog_out;
    logic [23:0] rd, av;
    int seed = 32'h5179, miscompares = 0, samples_checked = 0, cycles = 0, pulses = 0, p0, win;
    always #20 clk_in = ~clk_in;
    lock_regs i_dut (.clk_in, .rst_n_in, .sck_in, .sen_in, .sdi_in, .ref_edge_in, .vco_edge_in,
        .general_output_port_in, .sdo_out, .sdo_oe_out, .analog_out, .locked_out, .relock_req_out);
    serial_host i_host (.clk_in, .sdo_in(sdo_oe_out ? sdo_out : 1'b1), .oe_in(sdo_oe_out),
        .sck_out(sck_in), .sen_out(sen_in), .sdi_out(sdi_in));
    always @(posedge clk_in)
    begin
        cycles++;
        if (relock_req_out === 1'b1)
            pulses++;
        if (cycles == 60000)
        begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xf(input logic rw, input logic [2:0] c, input logic [4:0] a, input logic [23:0] d);
        i_host.xfer(rw, c, a, d, 3 + {$random(seed)} % 4, rd);
        repeat (2) @(negedge clk_in);
    endtask
    function automatic logic [23:0] ana(input logic [23:0] v);
        return {16'h0000, v[0], v[1], v[2], v[3], v[4], v[10], v[19], v[21]};
    endfunction
    // reference high half period, vco pulse d cycles after its rise
    task automatic periods(input int d, input int n);
        for (int p = 0; p < n * 64; p++)
        begin
            @(negedge clk_in);
            ref_edge_in = (p % 64) < 32;
            vco_edge_in = (p % 64) >= d && (p % 64) < d + 8;
        end
    endtask
    task automatic lock_cfg(input logic s, input logic [2:0] c, input logic [1:0] r);
        xf(1'b0, 3'h0, 5'h07, {10'h000, 1'b1, 1'b0, r, c, s, 3'b000, 3'b000});
        xf(1'b0, 3'h0, 5'h07, {10'h000, 1'b1, 1'b0, r, c, s, 3'b001, 3'b000});
    endtask
    initial
    begin
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clk_in);
        check(24'(analog_out), 24'h0000FC);
        xf(1'b1, 3'h0, 5'h08, 24'h000000);
        check(rd, 24'hC1BEFF);
        xf(1'b1, 3'h0, 5'h07, 24'h000000);
        check(rd, 24'h00014D);
        check(24'(i_host.oe_end), 24'h000001);
        xf(1'b1, 3'h0, 5'h03, 24'h000000);
        check(rd, 24'h000000);
        for (int k = 0; k < 5; k++)
        begin
            av = (k == 0) ? 24'h01BC20 : $random(seed);
            av[18:11] = 8'h37;
            av[5] = 1'b1;
            xf(1'b0, 3'h0, 5'h08, av);
            check(24'(analog_out), ana(av));
            xf(1'b1, 3'h0, 5'h08, 24'h000000);
            check(rd, av);
        end
        xf(1'b0, 3'h5, 5'h08, 24'h000000);
        check(24'(i_host.oe_end), 24'h000000);
        xf(1'b1, 3'h0, 5'h08, 24'h000000);
        check(rd, av);
        xf(1'b0, 3'h0, 5'h08, av & 24'hFFFFDF);
        xf(1'b1, 3'h0, 5'h08, 24'h000000);
        check(24'(i_host.oe_end), 24'h000000);
        check(rd, 24'hFFFFFF);
        xf(1'b0, 3'h0, 5'h08, av);
        xf(1'b0, 3'h0, 5'h0F, 24'h000080);
        general_output_port_in = 1'b1;
        repeat (10) @(negedge clk_in);
        check({23'h0, sdo_oe_out}, 24'h000001);
        check({23'h0, sdo_out}, 24'h000001);
        general_output_port_in = 1'b0;
        xf(1'b0, 3'h6, 5'h08, 24'h000000);
        check(24'(i_host.oe_end), 24'h000001);
        check({23'h0, sdo_out}, 24'h000000);
        xf(1'b0, 3'h0, 5'h0F, 24'h000000);
        for (int k = 0; k < 33; k++)
        begin
            lock_cfg(k < 32, 3'(k), 2'(k >> 3));
            win = (k < 32) ? ((k % 8 == 0) ? 1 : 1 << (k % 8 - 1)) << (k >> 3) : 1;
            periods(4, 7);
            if (win != 4)
                check({23'h0, locked_out}, 24'(win >= 8));
        end
        lock_cfg(1'b1, 3'h5, 2'h0);
        periods(4, 7);
        p0 = pulses;
        periods(40, 2);
        check(24'(pulses - p0), 24'h000001);
        check({23'h0, locked_out}, 24'h000000);
        periods(4, 7);
        periods(40, 2);
        check(24'(pulses - p0), 24'h000001);
        results();
    end
endmodule
bind lock_regs lock_regs_sva i_sva (.clk_in, .rst_n_in, .sen_in, .vco_edge_in, .general_output_port_in,
    .sdo_out, .sdo_oe_out, .analog_out, .locked_out, .relock_req_out);
`default_nettype wire

// File: hdl/lock_regs.sv
// lock detect and analog enable register bank with lock sequencing and output pad control
// Notes on behaviour
// - the window source bit picks the digital timer when 1 and the short one-shot window when 0.
// - the window length code gives half a cycle at 0, one cycle at 1, doubling up to 64 cycles at 7.
// - the timer rate field runs the window timer fastest at 00 and slowest at 11.
// - with relock on unlock set, the first lost lock after arming starts exactly one automatic relock attempt.
// - analog enable bits 0 to 4 drive the bias, charge pump, phase detector and both buffers; reset 0xC1BEFF.
// - with the pad enable cleared, the serial data output is never driven.
// - with pad enable set and register 0xF bit 7 set, the serial data output is driven all the time.
// - with pad enable set and that bit clear, the output is driven only during frames, and past the chip address bits only in frames for this chip address.
// - analog enable bit 10 drives the oscillator buffer and prescaler bias and resets to 1.
// - lock is declared only after the selected count of consecutive divided clocks land in the window.
// - lock detect bit 3 switches the lock monitor on and resets to 1.
`timescale 1ns/1ns
`default_nettype none
module lock_regs
(
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        sck_in,
    input  wire logic                        sen_in,
    input  wire logic                        sdi_in,
    input  wire logic                        ref_edge_in,
    input  wire logic                        vco_edge_in,
    input  wire logic                        general_output_port_in,
    output logic                             sdo_out,
    output logic                             sdo_oe_out,
    output lock_regs_pkg::analog_en_t        analog_out,
    output logic                             locked_out,
    output logic                             relock_req_out
);

    logic [23:0]               lock_q;
    logic [23:0]               lock_d;
    logic [23:0]               aen_q;
    logic [23:0]               aen_d;
    logic [23:0]               padq_q;
    logic [23:0]               padq_d;
    logic [23:0]               rdata;
    logic                      active;
    logic                      match;
    logic                      wr;
    logic [4:0]                addr;
    logic [23:0]               wdata;
    logic                      sdo_bit;
    lock_regs_pkg::lock_cfg_t  cfg;
    logic [1:0]                ref_s_q;
    logic [1:0]                vco_s_q;
    logic [1:0]                ref_e_q;
    logic [1:0]                vco_e_q;
    logic                      ref_tick;
    logic                      vco_tick;
    logic                      win_open;
    logic [15:0]               good_q;
    logic [15:0]               good_d;
    lock_regs_pkg::lock_state_t state_q;
    lock_regs_pkg::lock_state_t state_d;
    logic                      relock_d;
    logic                      used_q;
    logic                      used_d;
    logic                      sdo_d;
    logic                      oe_d;
    lock_regs_pkg::analog_en_t analog_d;

    // ----------------------------------------------------------------
    // lock count table
    // ----------------------------------------------------------------
    function automatic logic [15:0] count_target(input logic [2:0] code);
        case (code)
            3'h0: count_target = 16'h0005;
            3'h1: count_target = 16'h0020;
            3'h2: count_target = 16'h0060;
            3'h3: count_target = 16'h0100;
            3'h4: count_target = 16'h0200;
            3'h5: count_target = 16'h0800;
            3'h6: count_target = 16'h2000;
            default: count_target = 16'hFFFF;
        endcase
    endfunction

    serial_slave u_port
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .sck_in      (sck_in),
        .sen_in      (sen_in),
        .sdi_in      (sdi_in),
        .rdata_in    (rdata),
        .active_out  (active),
        .match_out   (match),
        .wr_out      (wr),
        .addr_out    (addr),
        .wdata_out   (wdata),
        .sdo_bit_out (sdo_bit)
    );

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_comb
    begin
        lock_d = lock_q;
        aen_d = aen_q;
        padq_d = padq_q;
        // whole words are stored, reserved bits included
        if (wr)
        begin
            if (addr == lock_regs_pkg::LOCK_CTRL_ADDR)
            begin
                lock_d = wdata;
            end
            else if (addr == lock_regs_pkg::ANALOG_EN_ADDR)
            begin
                aen_d = wdata;
            end
            else if (addr == lock_regs_pkg::PAD_QUAL_ADDR)
            begin
                padq_d = wdata;
            end
        end
        if (addr == lock_regs_pkg::LOCK_CTRL_ADDR)
        begin
            rdata = lock_q;
        end
        else if (addr == lock_regs_pkg::ANALOG_EN_ADDR)
        begin
            rdata = aen_q;
        end
        else if (addr == lock_regs_pkg::PAD_QUAL_ADDR)
        begin
            rdata = padq_q;
        end
        else
        begin
            rdata = 24'h000000;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            lock_q <= lock_regs_pkg::LOCK_CTRL_RST;
            aen_q <= lock_regs_pkg::ANALOG_EN_RST;
            padq_q <= 24'h000000;
        end
        else
        begin
            lock_q <= lock_d;
            aen_q <= aen_d;
            padq_q <= padq_d;
        end
    end

    // ----------------------------------------------------------------
    // config unpack
    // ----------------------------------------------------------------
    always_comb
    begin
        cfg.lock_count_threshold = lock_q[lock_regs_pkg::LCOUNT_MSB:lock_regs_pkg::LCOUNT_LSB];
        cfg.lock_monitor_on = lock_q[lock_regs_pkg::MONITOR_BIT];
        cfg.window_timer_source = lock_q[lock_regs_pkg::TSOURCE_BIT];
        cfg.window_length_code = lock_q[lock_regs_pkg::WLEN_MSB:lock_regs_pkg::WLEN_LSB];
        cfg.window_timer_rate = lock_q[lock_regs_pkg::TRATE_MSB:lock_regs_pkg::TRATE_LSB];
        cfg.relock_on_unlock = lock_q[lock_regs_pkg::RELOCK_BIT];
    end

    window_timer u_win
    (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .start_in       (ref_tick),
        .source_in      (cfg.window_timer_source),
        .length_code_in (cfg.window_length_code),
        .rate_in        (cfg.window_timer_rate),
        .open_out       (win_open)
    );

    // ----------------------------------------------------------------
    // lock detector
    // ----------------------------------------------------------------
    always_comb
    begin
        ref_tick = ref_e_q[0] && !ref_e_q[1];
        vco_tick = vco_e_q[0] && !vco_e_q[1];
        good_d = good_q;
        state_d = state_q;
        relock_d = 1'b0;
        used_d = used_q;
        if (vco_tick)
        begin
            good_d = win_open ? ((good_q == 16'hFFFF) ? good_q : good_q + 16'h0001) : 16'h0000;
        end
        if (!cfg.lock_monitor_on)
        begin
            state_d = lock_regs_pkg::LK_IDLE;
            good_d = 16'h0000;
            used_d = 1'b0;
        end
        else
        begin
            case (state_q)
                lock_regs_pkg::LK_IDLE:
                begin
                    if (good_q >= count_target(cfg.lock_count_threshold))
                    begin
                        state_d = lock_regs_pkg::LK_LOCKED;
                    end
                end
                lock_regs_pkg::LK_LOCKED:
                begin
                    if (vco_tick && !win_open)
                    begin
                        // only the first loss after arming may relock
                        relock_d = cfg.relock_on_unlock && !used_q;
                        state_d = relock_d ? lock_regs_pkg::LK_RELOCK : lock_regs_pkg::LK_FAILED;
                        used_d = 1'b1;
                    end
                end
                lock_regs_pkg::LK_RELOCK:
                begin
                    if (good_q >= count_target(cfg.lock_count_threshold))
                    begin
                        state_d = lock_regs_pkg::LK_LOCKED;
                    end
                end
                default:
                begin
                    // no second attempt until the detector is rearmed
                    state_d = lock_regs_pkg::LK_FAILED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            ref_s_q <= 2'h0;
            vco_s_q <= 2'h0;
            ref_e_q <= 2'h0;
            vco_e_q <= 2'h0;
            good_q <= 16'h0000;
            state_q <= lock_regs_pkg::LK_IDLE;
            locked_out <= 1'b0;
            relock_req_out <= 1'b0;
            used_q <= 1'b0;
        end
        else
        begin
            ref_s_q <= {ref_s_q[0], ref_edge_in};
            vco_s_q <= {vco_s_q[0], vco_edge_in};
            ref_e_q <= {ref_e_q[0], ref_s_q[1]};
            vco_e_q <= {vco_e_q[0], vco_s_q[1]};
            good_q <= good_d;
            state_q <= state_d;
            locked_out <= (state_d == lock_regs_pkg::LK_LOCKED);
            relock_req_out <= relock_d;
            used_q <= used_d;
        end
    end

    // ----------------------------------------------------------------
    // analog enables and output pad
    // ----------------------------------------------------------------
    always_comb
    begin
        analog_d.bias_on = aen_d[lock_regs_pkg::BIAS_BIT];
        analog_d.charge_pump_on = aen_d[lock_regs_pkg::CPUMP_BIT];
        analog_d.phase_detector_on = aen_d[lock_regs_pkg::PDET_BIT];
        analog_d.reference_buffer_on = aen_d[lock_regs_pkg::REFBUF_BIT];
        analog_d.oscillator_buffer_on = aen_d[lock_regs_pkg::OSCBUF_BIT];
        analog_d.oscillator_side_bias_on = aen_d[lock_regs_pkg::SIDE_BIAS_BIT];
        analog_d.halve_select = aen_d[lock_regs_pkg::HALVE_BIT];
        analog_d.high_reference_select = aen_d[lock_regs_pkg::HIREF_BIT];
        sdo_d = active ? sdo_bit : general_output_port_in;
        if (!aen_q[lock_regs_pkg::PAD_BIT])
        begin
            oe_d = 1'b0;
        end
        else if (padq_q[lock_regs_pkg::PAD_MODE_BIT])
        begin
            oe_d = 1'b1;
        end
        else
        begin
            oe_d = active && match;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            analog_out <= '0;
            sdo_out <= 1'b0;
            sdo_oe_out <= 1'b0;
        end
        else
        begin
            analog_out <= analog_d;
            sdo_out <= sdo_d;
            sdo_oe_out <= oe_d;
        end
    end

endmodule
`default_nettype wire

// File: hdl/lock_regs_pkg.sv
// constants and carrier types for the lock detect and analog enable register bank
package lock_regs_pkg;

    // ----------------------------------------------------------------
    // register addresses and widths
    // ----------------------------------------------------------------
    localparam int          REG_W          = 24;
    localparam int          ADDR_W         = 5;
    localparam int          CHIP_ADDR_W    = 3;
    localparam logic [4:0]  LOCK_CTRL_ADDR = 5'h07;
    localparam logic [4:0]  ANALOG_EN_ADDR = 5'h08;
    localparam logic [4:0]  PAD_QUAL_ADDR  = 5'h0F;
    localparam logic [23:0] LOCK_CTRL_RST  = 24'h00014D;
    localparam logic [23:0] ANALOG_EN_RST  = 24'hC1BEFF;

    // ----------------------------------------------------------------
    // lock detect field positions
    // ----------------------------------------------------------------
    localparam int LCOUNT_LSB    = 0;
    localparam int LCOUNT_MSB    = 2;
    localparam int MONITOR_BIT   = 3;
    localparam int TSOURCE_BIT   = 6;
    localparam int WLEN_LSB      = 7;
    localparam int WLEN_MSB      = 9;
    localparam int TRATE_LSB     = 10;
    localparam int TRATE_MSB     = 11;
    localparam int RELOCK_BIT    = 13;

    // ----------------------------------------------------------------
    // analog enable and pad qualifier field positions
    // ----------------------------------------------------------------
    localparam int BIAS_BIT      = 0;
    localparam int CPUMP_BIT     = 1;
    localparam int PDET_BIT      = 2;
    localparam int REFBUF_BIT    = 3;
    localparam int OSCBUF_BIT    = 4;
    localparam int PAD_BIT       = 5;
    localparam int SIDE_BIAS_BIT = 10;
    localparam int HALVE_BIT     = 19;
    localparam int HIREF_BIT     = 21;
    localparam int PAD_MODE_BIT  = 7;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          ONESHOT_NS     = 10;
    localparam int          CLK_NS         = 40;
    localparam int          ONESHOT_CYC    = (ONESHOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WIN_CNT_W      = 9;
    localparam int          LOCK_CNT_W     = 16;
    localparam int          PRESCALE_W     = 3;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] lock_count_threshold;
        logic       lock_monitor_on;
        logic       window_timer_source;
        logic [2:0] window_length_code;
        logic [1:0] window_timer_rate;
        logic       relock_on_unlock;
    } lock_cfg_t;

    typedef struct packed {
        logic bias_on;
        logic charge_pump_on;
        logic phase_detector_on;
        logic reference_buffer_on;
        logic oscillator_buffer_on;
        logic oscillator_side_bias_on;
        logic halve_select;
        logic high_reference_select;
    } analog_en_t;

    typedef enum logic [1:0] {
        LK_IDLE    = 2'b00,
        LK_LOCKED  = 2'b01,
        LK_RELOCK  = 2'b10,
        LK_FAILED  = 2'b11
    } lock_state_t;

endpackage

// File: hdl/serial_slave.sv
// serial register port: 1 r/w bit, chip address, register address, 24 data bits
`timescale 1ns/1ns
`default_nettype none
module serial_slave
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        sck_in,
    input  wire logic        sen_in,
    input  wire logic        sdi_in,
    input  wire logic [23:0] rdata_in,
    output logic             active_out,
    output logic             match_out,
    output logic             wr_out,
    output logic [4:0]       addr_out,
    output logic [23:0]      wdata_out,
    output logic             sdo_bit_out
);

    localparam logic [2:0] OWN_CHIP = 3'h0;

    logic [2:0]  sck_s_q;
    logic [1:0]  sen_s_q;
    logic [1:0]  sdi_s_q;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic [32:0] sh_q;
    logic [32:0] sh_d;
    logic [23:0] rd_q;
    logic [23:0] rd_d;
    logic        rise;
    logic        fall;
    logic        wr_d;
    logic        match_d;

    // ----------------------------------------------------------------
    // frame decode
    // ----------------------------------------------------------------
    always_comb
    begin
        rise = sck_s_q[1] && !sck_s_q[2];
        fall = !sck_s_q[1] && sck_s_q[2];
        cnt_d = cnt_q;
        sh_d = sh_q;
        rd_d = rd_q;
        wr_d = 1'b0;
        match_d = match_out;
        if (!sen_s_q[1])
        begin
            cnt_d = 6'h00;
            match_d = 1'b1;
        end
        else if (rise)
        begin
            sh_d = {sh_q[31:0], sdi_s_q[1]};
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == 6'h03)
            begin
                match_d = ({sh_q[1:0], sdi_s_q[1]} == OWN_CHIP);
            end
            if (cnt_q == 6'h08)
            begin
                rd_d = rdata_in;
            end
            if (cnt_q == 6'h20)
            begin
                wr_d = !sh_q[31] && match_out;
            end
        end
        else if (fall && cnt_q > 6'h09)
        begin
            rd_d = {rd_q[22:0], 1'b0};
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sck_s_q <= 3'h0;
            sen_s_q <= 2'h0;
            sdi_s_q <= 2'h0;
            cnt_q <= 6'h00;
            sh_q <= 33'h0;
            rd_q <= 24'h0;
            wr_out <= 1'b0;
            match_out <= 1'b1;
        end
        else
        begin
            sck_s_q <= {sck_s_q[1:0], sck_in};
            sen_s_q <= {sen_s_q[0], sen_in};
            sdi_s_q <= {sdi_s_q[0], sdi_in};
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            wr_out <= wr_d;
            match_out <= match_d;
        end
    end

    assign active_out = sen_s_q[1];
    // address still arriving when read data is loaded
    assign addr_out = (cnt_q > 6'h20) ? sh_q[28:24] : {sh_q[3:0], sdi_s_q[1]};
    assign wdata_out = sh_q[23:0];
    assign sdo_bit_out = rd_q[23];

endmodule
`default_nettype wire

// File: hdl/window_timer.sv
// lock window timer: digital programmable window or one-shot window
`timescale 1ns/1ns
`default_nettype none
module window_timer
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       start_in,
    input  wire logic       source_in,
    input  wire logic [2:0] length_code_in,
    input  wire logic [1:0] rate_in,
    output logic            open_out
);

    logic [lock_regs_pkg::WIN_CNT_W-1:0]  left_q;
    logic [lock_regs_pkg::WIN_CNT_W-1:0]  left_d;
    logic [lock_regs_pkg::PRESCALE_W-1:0] pre_q;
    logic [lock_regs_pkg::PRESCALE_W-1:0] pre_d;
    logic                                 tick;
    logic [lock_regs_pkg::WIN_CNT_W-1:0]  load;

    // ----------------------------------------------------------------
    // window length and timer rate
    // ----------------------------------------------------------------
    always_comb
    begin
        // code 0 is half a cycle, rounded up to one timer tick
        load = (length_code_in == 3'h0) ? 9'h001 : 9'(1 << (length_code_in - 3'h1));
        if (!source_in)
        begin
            load = 9'(lock_regs_pkg::ONESHOT_CYC);
        end
        // rate 0 ticks every clock, slower rates every 2, 4, 8 clocks
        // first tick a full timer period after start
        tick = source_in ? ((pre_q & 3'((1 << rate_in) - 1)) == 3'((1 << rate_in) - 1)) : 1'b1;
        pre_d = pre_q + 3'h1;
        left_d = left_q;
        if (start_in)
        begin
            left_d = load;
            pre_d = 3'h0;
        end
        else if (tick && left_q != 9'h000)
        begin
            left_d = left_q - 9'h001;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            left_q <= 9'h000;
            pre_q <= 3'h0;
            open_out <= 1'b0;
        end
        else
        begin
            left_q <= left_d;
            pre_q <= pre_d;
            open_out <= (left_d != 9'h000);
        end
    end

endmodule
`default_nettype wire
